// ---- verilog/sdrbw_burst_core.sv ----
// Functional notes
// R1: First read data valid after read latency, then one element per rising edge.
// R2: Data pins float once a read burst ends with nothing further pending.
// R3: Page bursts run until stopped and wrap from last column to column 0.
// R4: Controller issues the next READ read latency minus one before last wanted data.
// R5: A READ is accepted on any cycle after a READ, any bank.
// R6: A WRITE may follow the last wanted read element on the very next edge.
// R7: Controller leaves an idle cycle before WRITE if its drivers turn on early.
// R8: Byte mask gates read output two clocks later; raise it before truncating WRITE.
// R9: A truncating WRITE floats the data pins regardless of the mask.
// R10: Byte mask gates write data on the same edge; drop it before WRITE.
// R11: Controller ends a read with PRECHARGE only without auto precharge.
// R12: Controller waits row precharge time after PRECHARGE before using that bank.
// R13: Controller may stop reads with BURST TERMINATE read latency minus one early.
// R14: Write data is captured on the WRITE edge and each following edge.
// R15: After a fixed write burst, pins stay floating and extra data is dropped.
// R16: A new WRITE on any edge takes that edge's data and ends the old burst.
// R17: A READ ends a write burst; data from that edge on is not written.
// R18: Controller waits write recovery time after last write data before PRECHARGE.
// R19: Auto precharge after a write waits at least one full clock of recovery.
// R20: Controller masks write data around a truncating PRECHARGE at fast clocks.
// R21: BURST TERMINATE drops the data on its edge; the previous element is last.
// R22: Auto precharge closes the accessed row when its burst completes.
// R23: Read latency is two or three clocks and sets read data timing.
// R24: Write burst mode bit makes writes single column; reads keep burst length. The code ignores the bit at page length.
// R25: Auto precharge select bit on each READ or WRITE applies to that burst. The code ignores it for page bursts.
// R26: Command, address and mask inputs are sampled and decoded on rising edges.
`timescale 1ns/1ps
module sdrbw_burst_core
	import sdrbw_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CS_N_IN,
	input wire logic RAS_N_IN,
	input wire logic CAS_N_IN,
	input wire logic WE_N_IN,
	input wire logic [sdrbw_pkg::BANK_W-1:0] BANK_IN,
	input wire logic [sdrbw_pkg::COL_W-1:0] COL_ADDR_IN,
	input wire logic AUTOPRECHARGE_SELECT_BIT_IN,
	input wire logic DQM_IN,
	input wire logic [sdrbw_pkg::DATA_W-1:0] DQ_IN,
	input wire logic [1:0] READ_LATENCY_IN,
	input wire logic [2:0] BURST_LENGTH_SETTING_IN,
	input wire logic BURST_INTERLEAVE_IN,
	input wire logic WRITE_BURST_MODE_BIT_IN,
	output logic [sdrbw_pkg::DATA_W-1:0] DQ_OUT,
	output logic DQ_OE_OUT,
	output logic [sdrbw_pkg::NUM_BANKS-1:0] AUTO_PRECHARGE_OUT,
	output logic READ_BUSY_OUT,
	output logic WRITE_BUSY_OUT
);

	import sdrbw_pkg::*;

	// ----------------------------------------------------------------
	// Storage and state
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	logic is_rd, is_wr, is_pre, is_stop;
	logic rd_act, rd_ap, rd_page;
	logic [BANK_W-1:0] rd_bank;
	logic [COL_W-1:0] rd_start, rd_cnt, rd_mask, rd_col;
	logic wr_act, wr_ap, wr_page;
	logic [BANK_W-1:0] wr_bank;
	logic [COL_W-1:0] wr_start, wr_cnt, wr_mask, wr_col;
	logic st_vld, dqm_q;
	logic [DATA_W-1:0] st_data;
	logic [2:0] rec_cnt [NUM_BANKS];
	logic [NUM_BANKS-1:0] ap_pulse, wr_done, rd_fire;

	sdrbw_cmd_dec u_dec (
		.cs_n_in(CS_N_IN),
		.ras_n_in(RAS_N_IN),
		.cas_n_in(CAS_N_IN),
		.we_n_in(WE_N_IN),
		.read_out(is_rd),
		.write_out(is_wr),
		.precharge_out(is_pre),
		.stop_out(is_stop)
	);

	sdrbw_col_gen u_rd_col (
		.start_in(rd_start),
		.count_in(rd_cnt),
		.mask_in(rd_mask),
		.interleave_in(BURST_INTERLEAVE_IN),
		.col_out(rd_col)
	);

	sdrbw_col_gen u_wr_col (
		.start_in(wr_start),
		.count_in(wr_cnt),
		.mask_in(wr_mask),
		.interleave_in(BURST_INTERLEAVE_IN),
		.col_out(wr_col)
	);

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	wire cl3 = (READ_LATENCY_IN == READ_LATENCY_THREE);
	wire bl_page = (BURST_LENGTH_SETTING_IN == BL_PAGE);
	// Reserved length codes fall back to a single element
	wire [COL_W-1:0] bl_mask = bl_page ? MASK_PAGE :
		(BURST_LENGTH_SETTING_IN == BL_EIGHT) ? MASK_EIGHT :
		(BURST_LENGTH_SETTING_IN == BL_FOUR) ? MASK_FOUR :
		(BURST_LENGTH_SETTING_IN == BL_TWO) ? MASK_TWO : MASK_ONE;
	// Page length overrides single-write mode, as it does for auto precharge
	wire [COL_W-1:0] wr_mask_n = (WRITE_BURST_MODE_BIT_IN && !bl_page) ? MASK_ONE : bl_mask; // R24
	wire wr_single_n = (wr_mask_n == MASK_ONE) && !bl_page;
	// Auto precharge never applies to page bursts
	wire ap_n = AUTOPRECHARGE_SELECT_BIT_IN && !bl_page; // R25

	// ----------------------------------------------------------------
	// Burst end conditions
	// ----------------------------------------------------------------
	// The address bit widens a PRECHARGE to every bank
	wire rd_pre_hit = is_pre && (AUTOPRECHARGE_SELECT_BIT_IN || BANK_IN == rd_bank);
	wire wr_pre_hit = is_pre && (AUTOPRECHARGE_SELECT_BIT_IN || BANK_IN == wr_bank);
	wire rd_last = (rd_cnt == rd_mask) && !rd_page;
	wire wr_last = (wr_cnt == wr_mask) && !wr_page;
	wire rd_kill = is_wr || is_stop || rd_pre_hit; // R6 R11 R13
	wire wr_kill = is_rd || is_stop || wr_pre_hit; // R17 R21
	// An interrupting READ or WRITE starts the precharge of the old burst
	wire rd_ap_done = rd_act && rd_ap && (is_rd || is_wr || (rd_last && !rd_kill)); // R22
	wire wr_old_done = wr_act && wr_ap && (is_rd || is_wr || (wr_last && !wr_kill)); // R22
	wire wr_new_done = is_wr && ap_n && wr_single_n; // R22

	// ----------------------------------------------------------------
	// Write port: command edge uses the command's column directly
	// ----------------------------------------------------------------
	wire wr_cont = wr_act && !wr_kill && !is_wr;
	wire mem_we = !DQM_IN && (is_wr || wr_cont); // R10 R14 R15 R16
	wire [BANK_W+COL_W-1:0] wr_addr = is_wr ? {BANK_IN, COL_ADDR_IN} : {wr_bank, wr_col};
	wire [DATA_W-1:0] mem_rd = mem[{rd_bank, rd_col}];

	// ----------------------------------------------------------------
	// Read output path
	// ----------------------------------------------------------------
	// The engine issues one element per cycle; the extra stage adds a latency clock
	wire src_vld = cl3 ? st_vld : rd_act; // R23
	wire [DATA_W-1:0] src_data = cl3 ? st_data : mem_rd; // R1
	// Mask sampled one edge ago governs the edge after this one
	wire next_oe = src_vld && !dqm_q && !is_wr; // R8 R9

	// Array has no reset: contents are undefined until written
	always_ff @(posedge CORE_CLK_IN) begin
		if (mem_we) begin
			mem[wr_addr] <= DQ_IN; // R14
		end
	end

	// Read engine: a new READ replaces any burst at once
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rd_act <= 1'b0;
			rd_ap <= 1'b0;
			rd_page <= 1'b0;
			rd_bank <= '0;
			rd_start <= RST_COL;
			rd_cnt <= RST_COL;
			rd_mask <= RST_COL;
		end else if (is_rd) begin
			rd_act <= 1'b1; // R5
			rd_ap <= ap_n; // R25
			rd_page <= bl_page; // R24
			rd_bank <= BANK_IN;
			rd_start <= COL_ADDR_IN;
			rd_cnt <= RST_COL;
			rd_mask <= bl_mask;
		end else if (rd_kill || (rd_act && rd_last)) begin
			rd_act <= 1'b0;
		end else if (rd_act) begin
			rd_cnt <= rd_cnt + 10'h001; // R3
		end
	end

	// Write engine: counts the element for the next edge
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			wr_act <= 1'b0;
			wr_ap <= 1'b0;
			wr_page <= 1'b0;
			wr_bank <= '0;
			wr_start <= RST_COL;
			wr_cnt <= RST_COL;
			wr_mask <= RST_COL;
		end else if (is_wr) begin
			wr_act <= !wr_single_n; // R16 R24
			wr_ap <= ap_n;
			wr_page <= bl_page;
			wr_bank <= BANK_IN;
			wr_start <= COL_ADDR_IN;
			wr_cnt <= 10'h001;
			wr_mask <= wr_mask_n;
		end else if (wr_kill || (wr_act && wr_last)) begin
			wr_act <= 1'b0; // R15
		end else if (wr_act) begin
			wr_cnt <= wr_cnt + 10'h001; // R3
		end
	end

	// Output pipeline; a WRITE empties it so the pins float at once
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_vld <= 1'b0;
			st_data <= RST_DATA;
			dqm_q <= 1'b0;
			DQ_OE_OUT <= 1'b0;
			DQ_OUT <= RST_DATA;
		end else begin
			st_vld <= rd_act && !is_wr; // R9
			st_data <= mem_rd;
			dqm_q <= DQM_IN; // R8
			DQ_OE_OUT <= next_oe; // R2
			DQ_OUT <= src_data;
		end
	end

	// ----------------------------------------------------------------
	// Auto precharge, one recovery counter per bank
	// ----------------------------------------------------------------
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		assign wr_done[b] = (wr_old_done && wr_bank == 2'(b)) ||
			(wr_new_done && BANK_IN == 2'(b));
		assign rd_fire[b] = rd_ap_done && rd_bank == 2'(b);

		// Recovery starts at the last data edge, so a reload simply restarts it
		always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
			if (!RST_N_IN) begin
				rec_cnt[b] <= RST_REC;
				ap_pulse[b] <= 1'b0;
			end else begin
				if (wr_done[b]) begin
					rec_cnt[b] <= WR_REC_LOAD; // R19
				end else if (rec_cnt[b] != RST_REC) begin
					rec_cnt[b] <= rec_cnt[b] - 3'h1;
				end
				ap_pulse[b] <= rd_fire[b] || (rec_cnt[b] == 3'h1); // R19 R22
			end
		end

		ap_rec_wait_a: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN) // R19
			(wr_done[b] ##1 (!wr_done[b] && !rd_fire[b])) |=> !ap_pulse[b] ##1 ap_pulse[b])
			else $error("write auto precharge not after recovery");
	end

	assign AUTO_PRECHARGE_OUT = ap_pulse;
	assign READ_BUSY_OUT = rd_act;
	assign WRITE_BUSY_OUT = wr_act;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	sequence rd_cl2_s;
		is_rd && !cl3 && !DQM_IN ##1 !is_wr;
	endsequence

	sequence rd_cl3_s;
		is_rd && cl3 ##1 (!DQM_IN && !is_wr && cl3) ##1 !is_wr;
	endsequence

	rd_lat_two_a: assert property (rd_cl2_s |=> DQ_OE_OUT) // R1 R23
		else $error("read data not driven at latency two");
	rd_lat_three_a: assert property (rd_cl3_s |=> DQ_OE_OUT) // R1 R23
		else $error("read data not driven at latency three");
	rd_lat_early_a: assert property ((is_rd && cl3 && !rd_act && !st_vld) |=> !DQ_OE_OUT) // R23
		else $error("latency three drove too early");
	wr_float_a: assert property (is_wr |=> !DQ_OE_OUT) // R9
		else $error("pins driven after truncating write");
	rd_idle_float_a: assert property ((!rd_act)[*3] |=> !DQ_OE_OUT) // R2
		else $error("pins driven with no read pending");
	rd_mask_lat_a: assert property (DQM_IN |=> ##1 !DQ_OE_OUT) // R8
		else $error("read mask not applied two clocks later");
	wr_capture_a: assert property (is_wr |-> (mem_we == !DQM_IN)) // R10 R14 R16
		else $error("write data not taken on command edge");
	wr_after_rd_a: assert property ((is_rd || is_stop) |-> !mem_we) // R17 R21
		else $error("write continued after read or terminate");
	wr_idle_drop_a: assert property ((!wr_act && !is_wr) |-> !mem_we) // R15
		else $error("data written outside a burst");
	wr_single_a: assert property ((is_wr && WRITE_BURST_MODE_BIT_IN && !bl_page) |=> !wr_act) // R24
		else $error("single write mode ran a burst");
	rd_ap_done_a: assert property ((is_rd && ap_n && bl_mask == MASK_ONE) ##1 // R22
		(!is_rd && !is_wr && !is_pre && !is_stop) |=> (AUTO_PRECHARGE_OUT != '0))
		else $error("read auto precharge missing");
	rd_page_run_a: assert property ((is_rd && bl_page) ##1 (!rd_kill && !is_rd) |-> rd_act) // R3
		else $error("page read stopped without a command");

	// A fixed burst stops on its last element; running on would wrap and repeat its block
	sequence wr_end_s;
		wr_act && wr_last && !wr_kill && !is_wr;
	endsequence

	wr_burst_end_a: assert property (wr_end_s |=> !WRITE_BUSY_OUT) // R15
		else $error("fixed write burst ran past its length");
	rd_burst_end_a: assert property ((rd_act && rd_last && !is_rd) |=> !READ_BUSY_OUT) // R2
		else $error("fixed read burst ran past its length");

endmodule // sdrbw_burst_core

// ---- verilog/sdrbw_pkg.sv ----
package sdrbw_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int COL_W = 10;
	localparam int BANK_W = 2;
	localparam int DATA_W = 8;
	localparam int NUM_BANKS = 4;
	localparam int MEM_DEPTH = NUM_BANKS * (1 << COL_W);

	typedef logic [2:0] sdrbw_cmd_t;

	// ----------------------------------------------------------------
	// Command encodings as {ras_n, cas_n, we_n} with chip select low
	// ----------------------------------------------------------------
	localparam sdrbw_cmd_t CMD_READ = 3'h5;
	localparam sdrbw_cmd_t CMD_WRITE = 3'h4;
	localparam sdrbw_cmd_t CMD_PRECHARGE = 3'h2;
	localparam sdrbw_cmd_t CMD_BURST_STOP = 3'h6;

	// ----------------------------------------------------------------
	// Mode settings
	// ----------------------------------------------------------------
	localparam logic [2:0] BL_ONE = 3'h0;
	localparam logic [2:0] BL_TWO = 3'h1;
	localparam logic [2:0] BL_FOUR = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [COL_W-1:0] MASK_ONE = 10'h000;
	localparam logic [COL_W-1:0] MASK_TWO = 10'h001;
	localparam logic [COL_W-1:0] MASK_FOUR = 10'h003;
	localparam logic [COL_W-1:0] MASK_EIGHT = 10'h007;
	localparam logic [COL_W-1:0] MASK_PAGE = 10'h3FF;
	localparam logic [1:0] READ_LATENCY_THREE = 2'h3;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
	localparam logic [COL_W-1:0] RST_COL = 10'h000;
	localparam logic [2:0] RST_REC = 3'h0;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int WRITE_RECOVERY_TIME_PS = 15000;
	localparam int WR_REC_RAW = (WRITE_RECOVERY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WR_REC_CYC = (WR_REC_RAW < 1) ? 1 : WR_REC_RAW;
	localparam logic [2:0] WR_REC_LOAD = 3'(WR_REC_CYC);

endpackage

// ---- verilog/sdrbw_cmd_dec.sv ----
`timescale 1ns/1ps
module sdrbw_cmd_dec
	import sdrbw_pkg::*;
(
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	output logic read_out,
	output logic write_out,
	output logic precharge_out,
	output logic stop_out
);

	// ----------------------------------------------------------------
	// Command decode, sampled by the caller on the rising edge
	// ----------------------------------------------------------------
	wire sdrbw_cmd_t code = {ras_n_in, cas_n_in, we_n_in};
	wire selected = !cs_n_in;

	// Deselected or NOP never matches any of these codes
	assign read_out = selected && (code == CMD_READ); // R26
	assign write_out = selected && (code == CMD_WRITE); // R26
	assign precharge_out = selected && (code == CMD_PRECHARGE); // R26
	assign stop_out = selected && (code == CMD_BURST_STOP); // R26

endmodule // sdrbw_cmd_dec

// ---- verilog/sdrbw_col_gen.sv ----
`timescale 1ns/1ps
module sdrbw_col_gen
	import sdrbw_pkg::*;
(
	input wire logic [COL_W-1:0] start_in,
	input wire logic [COL_W-1:0] count_in,
	input wire logic [COL_W-1:0] mask_in,
	input wire logic interleave_in,
	output logic [COL_W-1:0] col_out
);

	// ----------------------------------------------------------------
	// Column of a burst element, wrapping inside its block
	// ----------------------------------------------------------------
	wire [COL_W-1:0] seq_col = start_in + count_in;
	wire [COL_W-1:0] int_col = start_in ^ count_in;
	// Interleave only makes sense for fixed blocks; page mode stays sequential
	wire [COL_W-1:0] offset = (interleave_in && mask_in != MASK_PAGE) ? int_col : seq_col;

	// A full page mask wraps past the last column straight to column 0
	assign col_out = (start_in & ~mask_in) | (offset & mask_in); // R3

endmodule // sdrbw_col_gen

// ---- test/sdrbw_ctrl_model.sv ----
`timescale 1ns/1ps
module sdrbw_ctrl_model
	import sdrbw_pkg::*;
(
	input wire logic clk_in,
	output logic cs_n_out,
	output logic ras_n_out,
	output logic cas_n_out,
	output logic we_n_out,
	output logic [sdrbw_pkg::BANK_W-1:0] bank_out,
	output logic [sdrbw_pkg::COL_W-1:0] col_out,
	output logic ap_out,
	output logic dqm_out,
	output logic [sdrbw_pkg::DATA_W-1:0] dq_out
);
	import sdrbw_pkg::*;

	// Idle bus until the first command
	initial begin
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
		bank_out = 2'h0;
		col_out = 10'h000;
		ap_out = 1'b0;
		dqm_out = 1'b0;
		dq_out = 8'h00;
	end

	// Driven just after an edge and held a whole cycle, so the device takes it on the next edge
	task automatic issue(input sdrbw_cmd_t c, input logic [BANK_W-1:0] b,
			input logic [COL_W-1:0] col, input logic a, input logic m, input logic [DATA_W-1:0] d);
		@(posedge clk_in);
		#1;
		cs_n_out = 1'b0;
		{ras_n_out, cas_n_out, we_n_out} = c;
		bank_out = b;
		col_out = col;
		ap_out = a;
		dqm_out = m;
		dq_out = d;
	endtask

	// Deselected cycle; command lines flip so a stale code never looks valid
	task automatic deselect(input logic m, input logic [DATA_W-1:0] d);
		@(posedge clk_in);
		#1;
		cs_n_out = 1'b1;
		{ras_n_out, cas_n_out, we_n_out} = ~{ras_n_out, cas_n_out, we_n_out};
		dqm_out = m;
		dq_out = d;
	endtask

	// Data lines not in use carry the inverse of the last value
	task automatic idle(input logic m);
		deselect(m, ~dq_out);
	endtask
endmodule // sdrbw_ctrl_model

// ---- test/sdrbw_burst_core_bench.sv ----
`timescale 1ns/1ps
module sdrbw_burst_core_bench;
	import sdrbw_pkg::*;

	logic clk, rst_n, cs_n, ras_n, cas_n, we_n, ap, dqm, il, wbm, mask_en, dq_oe;
	logic rd_busy, wr_busy;
	logic [1:0] bank, rl;
	logic [2:0] bl;
	logic [9:0] col;
	logic [7:0] dq, dq_out;
	logic [3:0] ap_out;
	logic [31:0] seed = 32'h0A78;
	logic [7:0] exp_mem [NUM_BANKS][1 << COL_W];
	logic [2:0] mode_tab [5] = '{BL_ONE, BL_TWO, BL_FOUR, BL_EIGHT, 3'h5};
	int checks, n_fail, cycles;

	sdrbw_ctrl_model ctl (.clk_in(clk), .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n),
		.we_n_out(we_n), .bank_out(bank), .col_out(col), .ap_out(ap), .dqm_out(dqm), .dq_out(dq));

	sdrbw_burst_core dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CS_N_IN(cs_n), .RAS_N_IN(ras_n),
		.CAS_N_IN(cas_n), .WE_N_IN(we_n), .BANK_IN(bank), .COL_ADDR_IN(col),
		.AUTOPRECHARGE_SELECT_BIT_IN(ap), .DQM_IN(dqm), .DQ_IN(dq), .READ_LATENCY_IN(rl),
		.BURST_LENGTH_SETTING_IN(bl), .BURST_INTERLEAVE_IN(il), .WRITE_BURST_MODE_BIT_IN(wbm),
		.DQ_OUT(dq_out), .DQ_OE_OUT(dq_oe), .AUTO_PRECHARGE_OUT(ap_out),
		.READ_BUSY_OUT(rd_busy), .WRITE_BUSY_OUT(wr_busy));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic int pick(input int n);
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return int'(seed & 32'hFFFF) % n;
	endfunction

	function automatic int blen(input logic [2:0] s);
		return (s == BL_PAGE) ? 1024 : (s > BL_EIGHT) ? 1 : (1 << s);
	endfunction

	// Column of element j; page bursts ignore the interleave setting
	function automatic logic [9:0] colf(input logic [9:0] c, input int j);
		logic [9:0] m;
		m = 10'(blen(bl) - 1);
		return (c & ~m) | (((il && bl != BL_PAGE) ? (c ^ 10'(j)) : (c + 10'(j))) & m);
	endfunction

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
		chk8(nm, {4'h0, e}, {4'h0, g});
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask

	// k elements sent; lm is the mask of the last one, kept low unless the caller masks it
	task automatic wr(input logic [1:0] b, input logic [9:0] c, input int k, input logic lm,
			input logic a);
		int nw;
		logic [7:0] d;
		logic m;
		nw = (wbm && bl != BL_PAGE) ? 1 : blen(bl);
		for (int j = 0; j < k; j++) begin
			d = 8'(pick(256));
			m = (j == k - 1) ? lm : (mask_en && pick(4) == 0);
			if (j == 0) ctl.issue(CMD_WRITE, b, c, a, m, d);
			else ctl.deselect(m, d);
			if (j < nw && !m) exp_mem[b][colf(c, j)] = d;
		end
	endtask

	// Read n elements; stop 1 terminates, stop 2 precharges all banks, latency minus one early
	task automatic rd_chk(input logic [1:0] b, input logic [9:0] c, input int n, input int stop);
		int cl;
		cl = (rl == READ_LATENCY_THREE) ? 3 : 2;
		ctl.issue(CMD_READ, b, c, 1'b0, 1'b0, 8'(pick(256)));
		for (int m = 1; m <= cl + n; m++) begin
			if (m == n && stop == 1) ctl.issue(CMD_BURST_STOP, b, c, 1'b0, 1'b0, 8'h00);
			else if (m == n && stop == 2) ctl.issue(CMD_PRECHARGE, b, c, 1'b1, 1'b0, 8'h00);
			else ctl.idle(1'b0);
			if (m == 1) chk1("rd_busy", 1'b1, rd_busy);
			if (m < cl) chk1("oe_lead", 1'b0, dq_oe);
			else if (m < cl + n) begin
				chk8("rd_data", exp_mem[b][colf(c, m - cl)], dq_out);
				chk1("oe_data", 1'b1, dq_oe);
			end
		end
		chk1("oe_end", 1'b0, dq_oe);
		chk1("rd_busy_end", 1'b0, rd_busy);
	endtask

	task automatic ap_chk(input logic w, input logic a, input logic [1:0] b, input int hi);
		if (w) wr(b, 10'h055, 1, 1'b0, a);
		else ctl.issue(CMD_READ, b, 10'h055, a, 1'b0, 8'h00);
		for (int m = 1; m <= hi + 1; m++) begin
			ctl.idle(1'b0);
			chk4("ap_pulse", (a && m == hi) ? 4'(1 << b) : 4'h0, ap_out);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Whole run is about 5300 cycles; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int k1, k2, t;
		logic [1:0] b1, b2;
		logic [9:0] c1, c2;
		rst_n = 1'b0; rl = 2'h2; bl = BL_PAGE; il = 1'b0; wbm = 1'b0; mask_en = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		chk1("oe_rst", 1'b0, dq_oe);
		chk4("ap_rst", 4'h0, ap_out);
		chk1("busy_rst", 1'b0, rd_busy | wr_busy);
		rst_n = 1'b1;
		// Page writes from a random column fill every column by wrapping
		for (int b = 0; b < NUM_BANKS; b++) begin
			wr(2'(b), 10'(pick(1024)), 1024, 1'b0, 1'b0);
			ctl.issue(CMD_BURST_STOP, 2'(b), 10'h000, 1'b0, 1'b0, 8'h00);
		end
		rd_chk(2'h0, 10'h3FE, 4, 1);
		rd_chk(2'h1, 10'h100, 3, 2);
		repeat (2) ctl.idle(1'b0);
		mask_en = 1'b1;
		for (int it = 0; it < 60; it++) begin
			bl = mode_tab[it % 5]; il = 1'(pick(2)); wbm = 1'(pick(2)); rl = 2'(pick(4));
			b1 = 2'(pick(4)); b2 = 2'(pick(4)); c1 = 10'(pick(1024)); c2 = 10'(pick(1024));
			k1 = 1 + pick(blen(bl) + 1);
			k2 = 1 + pick(blen(bl) + 1);
			t = pick(3);
			wr(b1, c1, k1, 1'b0, 1'b0);
			wr(b2, c2, k2, t == 2, 1'b0);
			if (t == 1) ctl.issue(CMD_BURST_STOP, b2, c2, 1'b0, 1'b0, 8'(pick(256)));
			if (t == 2) begin
				ctl.issue(CMD_PRECHARGE, b2, c2, 1'b0, 1'b1, 8'(pick(256)));
				ctl.idle(1'b0);
			end
			rd_chk(b1, c1, blen(bl), 0);
			rd_chk(b2, c2, blen(bl), 0);
		end
		// Reads on consecutive edges to all banks
		bl = BL_ONE; rl = 2'h2; mask_en = 1'b0;
		for (int j = 0; j < 6; j++) begin
			if (j < 4) ctl.issue(CMD_READ, 2'(j), 10'(j * 5), 1'b0, 1'b0, 8'h00);
			else ctl.idle(1'b0);
			if (j >= 2) chk8("rd_b2b", exp_mem[j - 2][10'((j - 2) * 5)], dq_out);
		end
		// Mask blanks one read element two clocks later, then output resumes
		bl = BL_FOUR;
		ctl.issue(CMD_READ, 2'h3, 10'h000, 1'b0, 1'b0, 8'h00);
		for (int m = 1; m <= 6; m++) begin
			ctl.idle(m == 1);
			if (m == 3) chk1("oe_dqm", 1'b0, dq_oe);
			if (m == 4) chk1("oe_resume", 1'b1, dq_oe);
			if (m == 5) chk8("rd_after_dqm", exp_mem[3][10'h003], dq_out);
		end
		// Write truncates a long read; mask raised two clocks ahead avoids contention
		bl = BL_EIGHT; il = 1'b0;
		ctl.issue(CMD_READ, 2'h1, 10'h010, 1'b0, 1'b0, 8'h00);
		ctl.idle(1'b1);
		ctl.idle(1'b1);
		chk8("rd_before_wr", exp_mem[1][10'h010], dq_out);
		wr(2'h2, 10'h020, 8, 1'b0, 1'b0);
		chk1("wr_busy", !wbm, wr_busy);
		for (int j = 0; j < 4; j++) begin
			chk1("oe_trunc", 1'b0, dq_oe);
			if (j == 1) chk1("wr_busy_end", 1'b0, wr_busy);
			ctl.idle(1'b0);
		end
		rd_chk(2'h2, 10'h020, 8, 0);
		// Auto precharge selected per command, off then on
		bl = BL_ONE;
		for (int a = 0; a < 2; a++) begin
			ap_chk(1'b1, 1'(a), 2'(pick(4)), 3);
			ap_chk(1'b0, 1'(a), 2'(pick(4)), 2);
		end
		print_verdict();
	end
endmodule // sdrbw_burst_core_bench
